// >>> rtl/icm_device.sv
// Interpolating complex modulator: APB control, three half-band
// stages, complex carrier mixer, inverse sinc, two DAC words.
// Assumes one clock at the DAC rate and a source on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"
module icm_device (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   icm_link_if.dev                link,
   output icm_pkg::icm_sample_t   dac_i,
   output icm_pkg::icm_sample_t   dac_q
);
   ////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  filt;
   logic [7:0]  data;
   logic [7:0]  next_filt;
   logic [7:0]  next_data;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   always_comb begin
      next_filt    = filt;
      next_data    = data;
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (psel && penable && !pready) begin
         next_pready = 1'b1;
         unique case (paddr)
            `ICM_ADDR_FILT: next_prdata = {24'h0, filt};
            `ICM_ADDR_DATA: next_prdata = {24'h0, data};
            `ICM_ADDR_STAT: begin
               next_prdata  = {dac_q, dac_i};
               next_pslverr = pwrite;
            end
            default: begin
               next_prdata  = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && pready && pwrite) begin
         if (paddr == `ICM_ADDR_FILT) begin
            next_filt = pwdata[7:0];
         end
         if (paddr == `ICM_ADDR_DATA) begin
            next_data = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt    <= `ICM_FILT_RST;
         data    <= `ICM_DATA_RST;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         filt    <= next_filt;
         data    <= next_data;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Rate counter and stage strobes
   logic [1:0] nst;
   logic [3:0] mode;
   logic       intlv;
   logic       real_m;
   logic       isinc;
   logic       shifted;
   logic [3:0] per;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic       word_en;

   assign nst     = filt[`ICM_INTERP_MSB:`ICM_INTERP_LSB];
   assign mode    = filt[`ICM_MODE_MSB:`ICM_MODE_LSB];
   assign intlv   = data[`ICM_BIT_INTLV];
   assign real_m  = data[`ICM_BIT_REAL];
   assign isinc   = data[`ICM_BIT_ISINC];
   assign shifted = mode[0] && !real_m && (nst != 2'h0);
   // A word per cycle cannot be interleaved, so 1x interleave runs at half rate
   assign per     = (nst == 2'h0 && intlv) ? 4'h2 : 4'h1 << nst;
   assign word_en = (cnt == 3'h0);

   // Stage k emits at (2^k)/per of the DAC rate
   function automatic logic stage_en(input logic [1:0] k);
      logic [3:0] m;
      m = (per >> k) - 4'h1;
      return (nst >= k) && (({1'b0, cnt} & m) == 4'h0);
   endfunction

   always_comb begin
      next_cnt = (4'({1'b0, cnt}) == per - 4'h1) ? 3'h0 : cnt + 3'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Input capture and half-rate premodulation for shifted modes
   icm_pkg::icm_sample_t x_i;
   icm_pkg::icm_sample_t x_q;
   icm_pkg::icm_sample_t hold_i;
   icm_pkg::icm_sample_t next_x_i;
   icm_pkg::icm_sample_t next_x_q;
   icm_pkg::icm_sample_t next_hold_i;
   icm_pkg::icm_sample_t raw_i;
   icm_pkg::icm_sample_t raw_q;
   logic                 phq;
   logic                 next_phq;
   logic                 sgn;
   logic                 next_sgn;
   logic                 path_en;
   logic                 next_take;
   logic                 next_take_q;

   always_comb begin
      next_hold_i = hold_i;
      next_phq    = phq;
      next_sgn    = sgn;
      next_x_i    = x_i;
      next_x_q    = x_q;
      next_take   = word_en;
      next_take_q = intlv && phq;
      path_en     = 1'b0;
      raw_i       = icm_pkg::icm_sample_t'(link.port1);
      raw_q       = icm_pkg::icm_sample_t'(link.port2);
      if (word_en) begin
         if (intlv) begin
            // First word of a pair is I; paths advance per pair
            next_phq = !phq;
            if (!phq) begin
               next_hold_i = raw_i;
            end else begin
               // Second word of the pair is Q and arrives on port 1
               raw_q   = raw_i;
               raw_i   = hold_i;
               path_en = 1'b1;
            end
         end else begin
            next_phq = 1'b0;
            path_en  = 1'b1;
         end
      end
      if (real_m) begin
         raw_q = '0;
      end
      if (path_en) begin
         next_sgn = !sgn;
         // Moved down by half the data rate, restored by the mixer
         next_x_i = (shifted && sgn) ? icm_pkg::icm_sat(-40'(raw_i)) : raw_i;
         next_x_q = (shifted && sgn) ? icm_pkg::icm_sat(-40'(raw_q)) : raw_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_i         <= '0;
         phq            <= 1'b0;
         sgn            <= 1'b0;
         x_i            <= '0;
         x_q            <= '0;
         link.word_take <= 1'b0;
         link.take_is_q <= 1'b0;
      end else begin
         hold_i         <= next_hold_i;
         phq            <= next_phq;
         sgn            <= next_sgn;
         x_i            <= next_x_i;
         x_q            <= next_x_q;
         link.word_take <= next_take;
         link.take_is_q <= next_take_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Half-band cascade; stage count sets passband width
   icm_pkg::icm_sample_t y1_i, y1_q, y2_i, y2_q, y3_i, y3_q;
   icm_pkg::icm_sample_t c_i;
   icm_pkg::icm_sample_t c_q;
   logic                 en1;
   logic                 en2;
   logic                 en3;

   // Strobes from the function here so they follow cnt and per
   always_comb begin
      en1 = stage_en(2'h1);
      en2 = stage_en(2'h2);
      en3 = stage_en(2'h3);
   end

   icm_hbf #(.STAGE(1)) u_hb1 (.pclk(pclk), .presetn(presetn), .en(en1),
      .x_i(x_i), .x_q(x_q), .y_i(y1_i), .y_q(y1_q));
   icm_hbf #(.STAGE(2)) u_hb2 (.pclk(pclk), .presetn(presetn), .en(en2),
      .x_i(y1_i), .x_q(y1_q), .y_i(y2_i), .y_q(y2_q));
   icm_hbf #(.STAGE(3)) u_hb3 (.pclk(pclk), .presetn(presetn), .en(en3),
      .x_i(y2_i), .x_q(y2_q), .y_i(y3_i), .y_q(y3_q));

   always_comb begin
      unique case (nst)
         2'h0: begin c_i = x_i;  c_q = x_q;  end
         2'h1: begin c_i = y1_i; c_q = y1_q; end
         2'h2: begin c_i = y2_i; c_q = y2_q; end
         2'h3: begin c_i = y3_i; c_q = y3_q; end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Carrier in sixteenths of the DAC rate, one step per sample
   logic [3:0] step;
   logic [3:0] cph;
   logic [3:0] next_cph;

   always_comb begin
      unique case (nst)
         2'h3: step = {mode[3:1], 1'b0};
         2'h2: step = {mode[2:1], 2'h0};
         2'h1: step = {mode[1], 3'h0};
         2'h0: step = 4'h0;
      endcase
      if (shifted) begin
         step = step + (4'h8 >> nst);
      end
      if (real_m) begin
         step = 4'h0;
      end
      next_cph = cph + step;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cph <= 4'h0;
      end else begin
         cph <= next_cph;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Complex mixer; negative steps give negative carriers
   icm_pkg::icm_sample_t m_i, m_q, next_m_i, next_m_q;
   icm_pkg::icm_acc_t    kc, ks;

   always_comb begin
      kc = 40'(icm_pkg::icm_cos(cph));
      ks = 40'(icm_pkg::icm_sin(cph));
      next_m_i = icm_pkg::icm_sat((40'(c_i) * kc - 40'(c_q) * ks) >>> `ICM_MIX_SHIFT);
      next_m_q = icm_pkg::icm_sat((40'(c_i) * ks + 40'(c_q) * kc) >>> `ICM_MIX_SHIFT);
      if (real_m) begin
         next_m_i = c_i;
         next_m_q = '0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Inverse sinc at the DAC rate
   icm_pkg::icm_sample_t si [9];
   icm_pkg::icm_sample_t sq [9];
   icm_pkg::icm_sample_t next_dac_i;
   icm_pkg::icm_sample_t next_dac_q;

   function automatic icm_pkg::icm_sample_t sinc9(input icm_pkg::icm_sample_t s [9]);
      icm_pkg::icm_acc_t a;
      a = 40'sh2 * (40'(s[0]) + 40'(s[8])) - 40'sh4 * (40'(s[1]) + 40'(s[7]))
        + 40'sha * (40'(s[2]) + 40'(s[6])) - 40'sh23 * (40'(s[3]) + 40'(s[5]))
        + 40'sh191 * 40'(s[4]);
      // Divided by the centre weight through its reciprocal
      return icm_pkg::icm_sat((a * `ICM_ISINC_RECIP) >>> `ICM_ISINC_SHIFT);
   endfunction

   always_comb begin
      next_dac_i = isinc ? sinc9(si) : m_i;
      next_dac_q = isinc ? sinc9(sq) : m_q;
      if (real_m) begin
         next_dac_q = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_i   <= '0;
         m_q   <= '0;
         dac_i <= '0;
         dac_q <= '0;
         for (int k = 0; k < 9; k++) begin
            si[k] <= '0;
            sq[k] <= '0;
         end
      end else begin
         m_i   <= next_m_i;
         m_q   <= next_m_q;
         dac_i <= next_dac_i;
         dac_q <= next_dac_q;
         si[0] <= m_i;
         sq[0] <= m_q;
         for (int k = 1; k < 9; k++) begin
            si[k] <= si[k-1];
            sq[k] <= sq[k-1];
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/icm_hbf.sv
// One half-band interpolate-by-2 stage on an I/Q pair
// Assumes x is held between its producer's update strobes
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"
module icm_hbf #(
   parameter int STAGE = 1
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              en,
   input  wire icm_pkg::icm_sample_t x_i,
   input  wire icm_pkg::icm_sample_t x_q,
   output icm_pkg::icm_sample_t   y_i,
   output icm_pkg::icm_sample_t   y_q
);
   localparam int T  = (STAGE == 1) ? 14 : (STAGE == 2) ? 6 : 4;
   localparam int SH = (STAGE == 1) ? `ICM_HB1_SHIFT :
                       (STAGE == 2) ? `ICM_HB2_SHIFT : `ICM_HB3_SHIFT;

   // Odd-offset taps outward from the centre
   function automatic icm_pkg::icm_acc_t coef(input int j);
      logic signed [17:0] c;
      c = 18'sh0;
      if (STAGE == 1) begin
         unique case (j)
            0: c = 18'sh05113; 1: c = -18'sh019f2; 2: c = 18'sh00e57;
            3: c = -18'sh0090b; 4: c = 18'sh005f1; 5: c = -18'sh003eb;
            6: c = 18'sh0028a;  7: c = -18'sh00198; 8: c = 18'sh000f5;
            9: c = -18'sh0008a; 10: c = 18'sh00048; 11: c = -18'sh00022;
            12: c = 18'sh0000d; default: c = -18'sh00004;
         endcase
      end else if (STAGE == 2) begin
         unique case (j)
            0: c = 18'sh009e2; 1: c = -18'sh00294; 2: c = 18'sh000ee;
            3: c = -18'sh0004b; 4: c = 18'sh00011; default: c = -18'sh00002;
         endcase
      end else begin
         unique case (j)
            0: c = 18'sh01364; 1: c = -18'sh0044e; 2: c = 18'sh00111;
            default: c = -18'sh00027;
         endcase
      end
      return icm_pkg::icm_acc_t'(c);
   endfunction

   icm_pkg::icm_sample_t di [2*T];
   icm_pkg::icm_sample_t dq [2*T];
   icm_pkg::icm_sample_t next_di [2*T];
   icm_pkg::icm_sample_t next_dq [2*T];
   icm_pkg::icm_sample_t next_y_i;
   icm_pkg::icm_sample_t next_y_q;
   logic                 ph;
   logic                 next_ph;
   icm_pkg::icm_acc_t    acc_i;
   icm_pkg::icm_acc_t    acc_q;

   always_comb begin
      acc_i = '0;
      acc_q = '0;
      for (int j = 0; j < T; j++) begin
         acc_i = acc_i + coef(j) * (icm_pkg::icm_acc_t'(di[T+j])
                 + icm_pkg::icm_acc_t'(di[T-1-j]));
         acc_q = acc_q + coef(j) * (icm_pkg::icm_acc_t'(dq[T+j])
                 + icm_pkg::icm_acc_t'(dq[T-1-j]));
      end
      next_di  = di;
      next_dq  = dq;
      next_ph  = ph;
      next_y_i = y_i;
      next_y_q = y_q;
      if (en) begin
         if (!ph) begin
            // Centre phase: tap times sample over tap is the sample
            next_y_i = di[T];
            next_y_q = dq[T];
            next_ph  = 1'b1;
         end else begin
            next_y_i = icm_pkg::icm_sat(acc_i >>> SH);
            next_y_q = icm_pkg::icm_sat(acc_q >>> SH);
            next_di[0] = x_i;
            next_dq[0] = x_q;
            for (int k = 1; k < 2*T; k++) begin
               next_di[k] = di[k-1];
               next_dq[k] = dq[k-1];
            end
            next_ph = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 2*T; k++) begin
            di[k] <= '0;
            dq[k] <= '0;
         end
         ph  <= 1'b0;
         y_i <= '0;
         y_q <= '0;
      end else begin
         di  <= next_di;
         dq  <= next_dq;
         ph  <= next_ph;
         y_i <= next_y_i;
         y_q <= next_y_q;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/icm_link_if.sv
// Parallel data link between baseband source and modulator
// Assumes both ends share pclk; no clocking block
`timescale 1ns/1ps
`default_nettype none
interface icm_link_if;
   logic [15:0] port1;
   logic [15:0] port2;
   logic        word_take;
   logic        take_is_q;

   modport dev (
      input  port1,
      input  port2,
      output word_take,
      output take_is_q
   );
   modport src (
      output port1,
      output port2,
      input  word_take,
      input  take_is_q
   );
endinterface
`default_nettype wire

// >>> rtl/icm_pkg.sv
// Shared types and arithmetic of the modulator datapath
// Assumes 16-bit two's complement samples
package icm_pkg;

   typedef logic signed [15:0] icm_sample_t;
   typedef logic signed [39:0] icm_acc_t;

   // Clip instead of wrapping
   function automatic icm_sample_t icm_sat(input icm_acc_t v);
      if (v > 40'sh00_0000_7fff) begin
         return 16'sh7fff;
      end else if (v < -40'sh00_0000_8000) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction

   // Quarter-wave magnitude, 16 phases per turn, scale 2^14
   function automatic icm_sample_t icm_qmag(input logic [2:0] r);
      unique case (r)
         3'h0:    return 16'sh4000;
         3'h1:    return 16'sh3b21;
         3'h2:    return 16'sh2d41;
         3'h3:    return 16'sh187e;
         default: return 16'sh0000;
      endcase
   endfunction

   function automatic icm_sample_t icm_cos(input logic [3:0] p);
      logic [2:0] r;
      logic [2:0] s;
      r = {1'b0, p[1:0]};
      s = 3'h4 - r;
      unique case (p[3:2])
         2'h0: return icm_qmag(r);
         2'h1: return -icm_qmag(s);
         2'h2: return -icm_qmag(r);
         2'h3: return icm_qmag(s);
      endcase
   endfunction

   function automatic icm_sample_t icm_sin(input logic [3:0] p);
      return icm_cos(p - 4'h4);
   endfunction

endpackage

// >>> rtl/icm_regs.svh
// Register map, field positions and reset values of the modulator and the source
// Assumes a 32-bit APB slave per end, one aligned word per register
`ifndef ICM_REGS_SVH
`define ICM_REGS_SVH

`define ICM_ADDR_FILT    12'h004
`define ICM_ADDR_DATA    12'h008
`define ICM_ADDR_STAT    12'h00c
`define ICM_ADDR_SAMPLE  12'h000
`define ICM_ADDR_SCTRL   12'h004
`define ICM_ADDR_SCOUNT  12'h008

`define ICM_INTERP_MSB   7
`define ICM_INTERP_LSB   6
`define ICM_MODE_MSB     5
`define ICM_MODE_LSB     2
`define ICM_BIT_INTLV    6
`define ICM_BIT_REAL     5
`define ICM_BIT_ISINC    0

`define ICM_FILT_RST     8'h00
`define ICM_DATA_RST     8'h00
`define ICM_SAMPLE_RST   32'h0000_0000

`define ICM_HB1_SHIFT    15
`define ICM_HB2_SHIFT    12
`define ICM_HB3_SHIFT    13
`define ICM_MIX_SHIFT    14
`define ICM_ISINC_RECIP  40'sh00_0000_00a3
`define ICM_ISINC_SHIFT  16

`endif

// >>> rtl/icm_source.sv
// Baseband source end: APB-loaded sample presented on the link
// Assumes the modulator shares pclk and marks each word it takes
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"
module icm_source (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   icm_link_if.src          link
);
   logic [31:0] sample, next_sample;
   logic        intlv, next_intlv;
   logic [31:0] words, next_words;
   logic        want_q, next_want_q;
   logic [15:0] next_p1, next_p2;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   ////////////////////////////////////////////////////////////////
   // Registers and link drive
   always_comb begin
      next_sample  = sample;
      next_intlv   = intlv;
      next_words   = words;
      next_want_q  = want_q;
      next_prdata  = prdata;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (psel && penable && !pready) begin
         next_pready = 1'b1;
         unique case (paddr)
            `ICM_ADDR_SAMPLE: next_prdata = sample;
            `ICM_ADDR_SCTRL:  next_prdata = {25'h0, intlv, 6'h0};
            `ICM_ADDR_SCOUNT: begin
               next_prdata  = words;
               next_pslverr = pwrite;
            end
            default: begin
               next_prdata  = 32'h0;
               next_pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && pready && pwrite) begin
         if (paddr == `ICM_ADDR_SAMPLE) begin
            next_sample = pwdata;
         end
         if (paddr == `ICM_ADDR_SCTRL) begin
            next_intlv = pwdata[`ICM_BIT_INTLV];
         end
      end
      // Ports hold until the device takes the word on them
      next_p1 = link.port1;
      next_p2 = link.port2;
      if (link.word_take) begin
         next_words  = words + 32'h1;
         // When interleaved, Q follows each taken I word, then the next I
         next_want_q = intlv && !link.take_is_q;
         next_p1 = next_want_q ? next_sample[31:16] : next_sample[15:0];
         // Port 2 unused when interleaved
         next_p2 = intlv ? 16'h0 : next_sample[31:16];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample     <= `ICM_SAMPLE_RST;
         intlv      <= 1'b0;
         words      <= 32'h0;
         want_q     <= 1'b0;
         prdata     <= 32'h0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         link.port1 <= 16'h0;
         link.port2 <= 16'h0;
      end else begin
         sample     <= next_sample;
         intlv      <= next_intlv;
         words      <= next_words;
         want_q     <= next_want_q;
         prdata     <= next_prdata;
         pready     <= next_pready;
         pslverr    <= next_pslverr;
         link.port1 <= next_p1;
         link.port2 <= next_p2;
      end
   end
endmodule
`default_nettype wire

// >>> verification/icm_link_asserts.sv
// Assertions on the link between the source and the modulator
// Assumes the link signals as plain inputs on the shared clock
`timescale 1ns/1ps
`default_nettype none
module icm_link_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [15:0] port1,
   input wire logic [15:0] port2,
   input wire logic        word_take,
   input wire logic        take_is_q
);
   logic [3:0] gap;
   logic [3:0] next_gap;
   logic [1:0] cyc;
   logic [1:0] next_cyc;
   logic       last_q;
   logic       next_last_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   // Cycles since last take, since reset, kind of last take
   always_comb begin
      next_gap = word_take ? 4'h1 : ((gap == 4'hf) ? gap : gap + 4'h1);
      next_cyc = (cyc == 2'h3) ? cyc : cyc + 2'h1;
      next_last_q = word_take ? take_is_q : last_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap    <= 4'h0;
         cyc    <= 2'h0;
         last_q <= 1'b1;
      end else begin
         gap    <= next_gap;
         cyc    <= next_cyc;
         last_q <= next_last_q;
      end
   end
   ////////////////////////////////////////////////////////////////
   sequence take_i;
      word_take && !take_is_q;
   endsequence
   sequence take_q;
      word_take && take_is_q;
   endsequence
   a_no_early: assert property (cyc == 2'h0 |-> !word_take)
      else $error("word taken before first sample");
   a_first_take: assert property (cyc == 2'h1 |-> take_i)
      else $error("first take missing or not in-phase");
   a_take_bound: assert property (gap <= 4'h8)
      else $error("take period above eight cycles");
   a_q_after_i: assert property (take_q |-> !last_q)
      else $error("quadrature take without in-phase take");
   a_q_gap: assert property (take_q |-> gap >= 4'h2 && gap <= 4'h8)
      else $error("interleaved take spacing wrong");
   a_q_single: assert property (take_q |=> !take_is_q || !word_take)
      else $error("two quadrature takes in a row");
   a_port1_hold: assert property ($changed(port1) |-> $past(word_take))
      else $error("first port changed without a take");
   a_port2_hold: assert property ($changed(port2) |-> $past(word_take))
      else $error("second port changed without a take");
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Bench joining source and modulator over the link, driven over APB
// Assumes both ends on pclk, bus 0 the modulator, bus 1 the source
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"
module tb;
   logic        pclk;
   logic        presetn;
   logic [11:0] pa [2];
   logic        ps [2];
   logic        pe [2];
   logic        pw [2];
   logic [31:0] pwd [2];
   logic [31:0] prd [2];
   logic        prdy [2];
   logic        perr [2];
   logic [31:0] r;
   logic [31:0] c;
   logic        e;
   int          fail_count;
   int          n_checks;
   icm_link_if link ();
   icm_device i_icm_device (.pclk(pclk), .presetn(presetn), .paddr(pa[0]), .psel(ps[0]),
      .penable(pe[0]), .pwrite(pw[0]), .pwdata(pwd[0]), .prdata(prd[0]), .pready(prdy[0]),
      .pslverr(perr[0]), .link(link.dev), .dac_i(), .dac_q());
   icm_source i_icm_source (.pclk(pclk), .presetn(presetn), .paddr(pa[1]), .psel(ps[1]),
      .penable(pe[1]), .pwrite(pw[1]), .pwdata(pwd[1]), .prdata(prd[1]), .pready(prdy[1]),
      .pslverr(perr[1]), .link(link.src));
   icm_link_asserts i_icm_link_asserts (.pclk(pclk), .presetn(presetn), .port1(link.port1),
      .port2(link.port2), .word_take(link.word_take), .take_is_q(link.take_is_q));
   ////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic signed [17:0] ab(input logic signed [17:0] v);
      return (v < 0) ? -v : v;
   endfunction
   // Small filter ripple allowed
   task automatic near(input logic signed [17:0] v, input logic signed [17:0] x);
      chk((ab(v - x) <= 18'sh00008) ? 32'(x) : 32'(v), 32'(x));
   endtask
   task automatic apb(input int b, input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      ps[b]  <= 1'b1;
      pw[b]  <= w;
      pa[b]  <= a;
      pwd[b] <= d;
      @(posedge pclk);
      pe[b] <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (prdy[b] !== 1'b1 && k < 20);
      r = prd[b];
      e = perr[b];
      ps[b] <= 1'b0;
      pe[b] <= 1'b0;
      if (k >= 20) begin
         fail_count++;
         final_report();
      end
   endtask
   task automatic run(input logic [7:0] f, input logic [7:0] d, input logic [31:0] s,
                      input logic signed [17:0] ei, input logic signed [17:0] eq,
                      input logic mag);
      apb(1, 1'b1, `ICM_ADDR_SAMPLE, s);
      apb(1, 1'b1, `ICM_ADDR_SCTRL, {25'h0, d[6], 6'h0});
      apb(0, 1'b1, `ICM_ADDR_FILT, {24'h0, f});
      apb(0, 1'b1, `ICM_ADDR_DATA, {24'h0, d});
      apb(0, 1'b0, `ICM_ADDR_FILT, 32'h0);
      chk(r, {24'h0, f});
      repeat (300) @(posedge pclk);
      apb(0, 1'b0, `ICM_ADDR_STAT, 32'h0);
      if (mag) near(ab(18'($signed(r[15:0]))) + ab(18'($signed(r[31:16]))), ei);
      else begin
         near(18'($signed(r[15:0])), ei);
         near(18'($signed(r[31:16])), eq);
      end
   endtask
   // Waits for a take of the given kind and checks the word on the wire
   task automatic watch(input logic q, input logic [15:0] v);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (!(link.word_take === 1'b1 && link.take_is_q === q) && k < 40);
      if (k >= 40) begin
         fail_count++;
         final_report();
      end
      chk({16'h0, link.port1}, {16'h0, v});
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      fail_count = 0;
      n_checks = 0;
      presetn = 1'b0;
      for (int b = 0; b < 2; b++) begin
         ps[b] = 1'b0;
         pe[b] = 1'b0;
         pw[b] = 1'b0;
         pa[b] = 12'h000;
         pwd[b] = 32'h0;
      end
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 1'b0, `ICM_ADDR_DATA, 32'h0);
      chk(r, 32'h0);
      apb(0, 1'b0, 12'h010, 32'h0);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(0, 1'b1, `ICM_ADDR_STAT, 32'hff);
      chk({31'h0, e}, 32'h1);
      run(8'h00, 8'h00, 32'h0800_1000, 18'sh01000, 18'sh00800, 1'b0);
      run(8'h00, 8'h40, 32'h0800_1000, 18'sh01000, 18'sh00800, 1'b0);
      watch(1'b0, 16'h1000);
      watch(1'b1, 16'h0800);
      apb(1, 1'b0, `ICM_ADDR_SCOUNT, 32'h0);
      c = r;
      repeat (40) @(posedge pclk);
      apb(1, 1'b0, `ICM_ADDR_SCOUNT, 32'h0);
      near(18'(r - c), 18'sh00016);
      run(8'h40, 8'h20, 32'h0800_1000, 18'sh01000, 18'sh00000, 1'b0);
      run(8'h00, 8'h01, 32'h0000_1000, 18'sh00dcf, 18'sh00000, 1'b0);
      run(8'h40, 8'h00, 32'h0800_1000, 18'sh01000, 18'sh00800, 1'b0);
      run(8'hc0, 8'h00, 32'h0800_1000, 18'sh01000, 18'sh00800, 1'b0);
      run(8'h48, 8'h00, 32'h0000_1000, 18'sh01000, 18'sh00000, 1'b1);
      run(8'hd0, 8'h00, 32'h0000_1000, 18'sh01000, 18'sh00000, 1'b1);
      run(8'h98, 8'h00, 32'h0000_1000, 18'sh01000, 18'sh00000, 1'b1);
      run(8'h80, 8'h00, 32'h0800_1000, 18'sh01000, 18'sh00800, 1'b0);
      run(8'h80, 8'h00, 32'h0000_0400, 18'sh00400, 18'sh00000, 1'b0);
      run(8'hc0, 8'h00, 32'h0000_f000, -18'sh01000, 18'sh00000, 1'b0);
      run(8'h40, 8'h00, 32'h0000_7fff, 18'sh07fff, 18'sh00000, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
